//--- src/fpuac_top.sv
// fpuac_top: fpu access gate, interrupt context stacking and arithmetic mode registers
// assumes: core holds fpIssue until fpExecute or noCoprocessorFault, and answers
// fpRegRdData combinationally for cnt_q; avalon-mm slave with waitrequest
//
// Function
// - disabled unit faults fp instructions, enabled executes
// - no stacking: integer-only frame, no fp save
// - lazy: reserve fp space, write nothing
// - lazy: save context before first handler fp instruction
// - lazy: restore on return only if saved
// - full: save on entry, always restore on return
// - frame 8 words, or 26 with fp
// - flush-to-zero setting, off after reset
// - half-precision format select, standard by default
// - nan handling select, propagate by default
// - rounding mode select, nearest by default
// - unit disabled after reset
// - lazy stacking after reset
// - individually enabled fp exception interrupts
//
// The register offsets and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "fpuac_consts.svh"

module fpuac_top
    import fpuac_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clkEn,
    input wire fpuac_avs_req_t avsReq,
    output fpuac_avs_rsp_t avsRsp_q,
    input wire logic fpIssue,
    input wire logic excEntry,
    input wire logic excReturn,
    input wire logic [5:0] fpExcFlags,
    input wire logic [31:0] fpRegRdData,
    output logic fpExecute_q,
    output logic noCoprocessorFault_q,
    output logic [4:0] cnt_q,
    output logic stackPush_q,
    output logic [4:0] stackWordIdx_q,
    output logic [4:0] frameWords_q,
    output logic entryDone_q,
    output logic returnDone_q,
    output logic restoreValid_q,
    output logic [3:0] restoreIdx_q,
    output logic [31:0] restoreData_q,
    output fpuac_ctrl_t ctrl_q,
    output logic irq_q
);

    // count of frame words, also the fp register index during save
    function automatic logic [4:0] fpuac_inc(input logic [4:0] v);
        fpuac_inc = v + 5'h01;
    endfunction : fpuac_inc

    logic reqActive; // read or write pending
    logic acceptWr; // write takes effect at this edge
    logic acceptRd; // read data captured at this edge
    logic selCtrl;
    logic selStatus;
    logic selIrqStat;
    logic selIrqMask;
    logic [31:0] rdMux; // read data selected by address
    logic [6:0] irqStat_q;
    logic [6:0] irqStat_d;
    logic [6:0] irqMask_q;
    logic [6:0] irqEvents; // this cycle's sticky-bit sources
    logic [6:0] w1cBits; // bits software clears this cycle
    logic fault_d; // no-coprocessor fault raised this cycle

    assign reqActive = avsReq.read | avsReq.write;
    assign acceptWr = avsReq.write & ~avsRsp_q.waitrequest;
    assign acceptRd = avsReq.read & avsRsp_q.waitrequest;
    assign selCtrl = avsReq.address == `FPUAC_OFS_CTRL;
    assign selStatus = avsReq.address == `FPUAC_OFS_STATUS;
    assign selIrqStat = avsReq.address == `FPUAC_OFS_IRQ_STAT;
    assign selIrqMask = avsReq.address == `FPUAC_OFS_IRQ_MASK;

    fpuac_state_t state_q;
    fpuac_state_t state_d;
    logic lazyPend_q; // space reserved, context not yet written
    logic lazyPend_d;
    logic saved_q; // fp context sits in the frame
    logic saved_d;
    logic inHandler;

    assign inHandler = state_q != FPUAC_IDLE;

    // unmapped offsets read as zero
    assign rdMux = selCtrl ? {24'h00_0000, ctrl_q} :
                   selStatus ? {22'h00_0000, frameWords_q, 2'h0, saved_q, lazyPend_q, inHandler} :
                   selIrqStat ? {25'h000_0000, irqStat_q} :
                   selIrqMask ? {25'h000_0000, irqMask_q} : 32'h0000_0000;

    // waitrequest drops for exactly one cycle per request, giving a two-edge answer
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            avsRsp_q <= '{waitrequest: 1'b1, readdata: 32'h0000_0000};
        else if (clkEn)
        begin
            avsRsp_q.waitrequest <= ~(reqActive & avsRsp_q.waitrequest);
            if (acceptRd)
                avsRsp_q.readdata <= rdMux;
        end
    end

    // control register; unit disabled and lazy stacking after reset
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            ctrl_q <= `FPUAC_CTRL_RESET;
        else if (clkEn && acceptWr && selCtrl)
            ctrl_q <= avsReq.writedata[7:0];
    end

    assign irqEvents = {fault_d, fpExcFlags};
    assign w1cBits = (acceptWr && selIrqStat) ? avsReq.writedata[6:0] : 7'h00;
    // set wins over a clear landing in the same cycle
    assign irqStat_d = (irqStat_q & ~w1cBits) | irqEvents;

    // sticky status, mask and the level interrupt
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            irqStat_q <= 7'h00;
            irqMask_q <= 7'h00;
            irq_q <= 1'b0;
        end
        else if (clkEn)
        begin
            irqStat_q <= irqStat_d;
            if (acceptWr && selIrqMask)
                irqMask_q <= avsReq.writedata[6:0];
            irq_q <= |(irqStat_d & irqMask_q);
        end
    end

    logic issueGuard_q; // blocks the request still high while the answer shows
    logic issueReq; // fp instruction waiting for a verdict
    logic exec_d;
    logic [4:0] cnt_d;
    logic push_d;
    logic [4:0] wordIdx_d;
    logic [4:0] frame_d;
    logic entryDone_d;
    logic returnDone_d;
    logic memWe;
    logic memRe;
    logic fullEntry_q; // entry mode latched so a mid-handler write cannot upset it
    logic fullEntry_d;

    assign issueReq = fpIssue & ~issueGuard_q;

    // next state of the entry/save/restore sequencer
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        push_d = 1'b0;
        wordIdx_d = stackWordIdx_q;
        frame_d = frameWords_q;
        lazyPend_d = lazyPend_q;
        saved_d = saved_q;
        fullEntry_d = fullEntry_q;
        exec_d = 1'b0;
        fault_d = 1'b0;
        entryDone_d = 1'b0;
        returnDone_d = 1'b0;
        memWe = 1'b0;
        memRe = 1'b0;
        unique case (state_q)
            FPUAC_IDLE:
            begin
                if (excEntry)
                begin
                    // lazy and full both reserve the fp area; none keeps the short frame
                    state_d = FPUAC_STACK;
                    cnt_d = 5'h00;
                    frame_d = (ctrl_q.stackMode == `FPUAC_STACK_FULL || ctrl_q.stackMode == `FPUAC_STACK_LAZY)
                              ? `FPUAC_FRAME_FP_WORDS : `FPUAC_FRAME_INT_WORDS;
                    lazyPend_d = ctrl_q.stackMode == `FPUAC_STACK_LAZY;
                    fullEntry_d = ctrl_q.stackMode == `FPUAC_STACK_FULL;
                    saved_d = 1'b0;
                end
                else if (issueReq)
                begin
                    fault_d = ~ctrl_q.enable;
                    exec_d = ctrl_q.enable;
                end
            end
            FPUAC_STACK:
            begin
                // integer words only; fp words follow only for full stacking
                push_d = 1'b1;
                wordIdx_d = cnt_q;
                cnt_d = fpuac_inc(cnt_q);
                if (cnt_q == `FPUAC_INT_LAST)
                begin
                    cnt_d = 5'h00;
                    if (fullEntry_q)
                        state_d = FPUAC_SAVE;
                    else
                    begin
                        state_d = FPUAC_HANDLER;
                        entryDone_d = 1'b1;
                    end
                end
            end
            FPUAC_SAVE:
            begin
                // sixteen registers then status and reserved words, 18 in all
                push_d = 1'b1;
                wordIdx_d = cnt_q + `FPUAC_FRAME_INT_WORDS;
                memWe = cnt_q < `FPUAC_FP_REGS;
                cnt_d = fpuac_inc(cnt_q);
                if (cnt_q == `FPUAC_FP_SAVE_LAST)
                begin
                    state_d = FPUAC_HANDLER;
                    saved_d = 1'b1;
                    lazyPend_d = 1'b0;
                    entryDone_d = fullEntry_q; // full entry only ends once fp words are out
                    cnt_d = 5'h00;
                end
            end
            FPUAC_HANDLER:
            begin
                if (excReturn)
                begin
                    cnt_d = 5'h00;
                    if (saved_q)
                        state_d = FPUAC_RESTORE;
                    else
                    begin
                        state_d = FPUAC_IDLE;
                        returnDone_d = 1'b1;
                        lazyPend_d = 1'b0;
                    end
                end
                else if (issueReq)
                begin
                    if (!ctrl_q.enable)
                        fault_d = 1'b1;
                    else if (lazyPend_q)
                    begin
                        // request stays held; it executes after the save ends
                        state_d = FPUAC_SAVE;
                        cnt_d = 5'h00;
                    end
                    else
                        exec_d = 1'b1;
                end
            end
            FPUAC_RESTORE:
            begin
                memRe = 1'b1;
                cnt_d = fpuac_inc(cnt_q);
                if (cnt_q == `FPUAC_FP_REG_LAST)
                begin
                    state_d = FPUAC_IDLE;
                    returnDone_d = 1'b1; // lines up with the last restored word
                    saved_d = 1'b0;
                    cnt_d = 5'h00;
                end
            end
            default:
            begin
                state_d = FPUAC_IDLE;
                cnt_d = 5'h00;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            state_q <= FPUAC_IDLE;
            cnt_q <= 5'h00;
            lazyPend_q <= 1'b0;
            saved_q <= 1'b0;
            fullEntry_q <= 1'b0;
            frameWords_q <= `FPUAC_FRAME_INT_WORDS;
        end
        else if (clkEn)
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            lazyPend_q <= lazyPend_d;
            saved_q <= saved_d;
            fullEntry_q <= fullEntry_d;
            frameWords_q <= frame_d;
        end
    end

    // one-cycle strobes towards the core
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            fpExecute_q <= 1'b0;
            noCoprocessorFault_q <= 1'b0;
            issueGuard_q <= 1'b0;
            stackPush_q <= 1'b0;
            stackWordIdx_q <= 5'h00;
            entryDone_q <= 1'b0;
            returnDone_q <= 1'b0;
            restoreValid_q <= 1'b0;
            restoreIdx_q <= 4'h0;
        end
        else if (clkEn)
        begin
            fpExecute_q <= exec_d;
            noCoprocessorFault_q <= fault_d;
            issueGuard_q <= exec_d | fault_d;
            stackPush_q <= push_d;
            stackWordIdx_q <= wordIdx_d;
            entryDone_q <= entryDone_d;
            returnDone_q <= returnDone_d;
            restoreValid_q <= memRe; // trails the memory read by one cycle
            restoreIdx_q <= cnt_q[3:0];
        end
    end

    // saved fp registers; core register file reads follow cnt_q
    fpuac_ctx_mem u_ctxMem (.clk_sys(clk_sys), .reset(reset), .clkEn(clkEn), .wrEn(memWe), .wrIdx(cnt_q[3:0]),
        .wrData(fpRegRdData), .rdEn(memRe), .rdIdx(cnt_q[3:0]), .rdData_q(restoreData_q));

endmodule : fpuac_top

`default_nettype wire

//--- src/fpuac_consts.svh
// fpuac_consts.svh: offsets, reset values, encodings and frame sizes of the fpu access/context block
// assumes: included by the package and by the design files by bare name
`ifndef FPUAC_CONSTS_SVH
`define FPUAC_CONSTS_SVH

// register byte offsets on the avalon slave
`define FPUAC_OFS_CTRL 4'h0
`define FPUAC_OFS_STATUS 4'h4
`define FPUAC_OFS_IRQ_STAT 4'h8
`define FPUAC_OFS_IRQ_MASK 4'hC

// control register reset: unit off, lazy stacking, all arithmetic modes at default
`define FPUAC_CTRL_RESET 8'h04

// stacking method encodings
`define FPUAC_STACK_NONE 2'h0
`define FPUAC_STACK_FULL 2'h1
`define FPUAC_STACK_LAZY 2'h2

// rounding mode encodings
`define FPUAC_ROUND_NEAREST 2'h0
`define FPUAC_ROUND_UP_POSITIVE 2'h1
`define FPUAC_ROUND_DOWN_NEGATIVE 2'h2
`define FPUAC_ROUND_ZERO 2'h3

// exception frame sizes in words and counter end values
`define FPUAC_FRAME_INT_WORDS 5'h08
`define FPUAC_FRAME_FP_WORDS 5'h1A
`define FPUAC_INT_LAST 5'h07
`define FPUAC_FP_REGS 5'h10
`define FPUAC_FP_SAVE_LAST 5'h11
`define FPUAC_FP_REG_LAST 5'h0F

// interrupt status layout: six arithmetic exceptions then the no-coprocessor fault
`define FPUAC_IRQ_BITS 7
`define FPUAC_EXC_BITS 6

`endif

//--- src/fpuac_pkg.sv
// fpuac_pkg: types shared by the fpu access/context block and its context memory
// assumes: the constants header sits beside this file
`include "fpuac_consts.svh"

package fpuac_pkg;

    // avalon-mm request from the bus master
    typedef struct packed {
        logic read;
        logic write;
        logic [3:0] address;
        logic [31:0] writedata;
    } fpuac_avs_req_t;

    // avalon-mm answer to the bus master
    typedef struct packed {
        logic waitrequest;
        logic [31:0] readdata;
    } fpuac_avs_rsp_t;

    // control register layout, msb first
    typedef struct packed {
        logic [1:0] roundMode;
        logic nanDefault;
        logic halfAlt;
        logic flushZero;
        logic [1:0] stackMode;
        logic enable;
    } fpuac_ctrl_t;

    // arithmetic settings handed to the datapath
    typedef struct packed {
        logic flushZero;
        logic halfAlt;
        logic nanDefault;
        logic [1:0] roundMode;
    } fpuac_modes_t;

    // context sequencer states, one-hot
    typedef enum logic [4:0] {
        FPUAC_IDLE = 5'h01,
        FPUAC_STACK = 5'h02,
        FPUAC_SAVE = 5'h04,
        FPUAC_HANDLER = 5'h08,
        FPUAC_RESTORE = 5'h10
    } fpuac_state_t;

endpackage : fpuac_pkg

//--- src/fpuac_ctx_mem.sv
// fpuac_ctx_mem: sixteen-word store for the saved floating-point registers
// assumes: one write and one read port, read data come out one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none

module fpuac_ctx_mem
    import fpuac_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic wrEn,
    input wire logic [3:0] wrIdx,
    input wire logic [31:0] wrData,
    input wire logic rdEn,
    input wire logic [3:0] rdIdx,
    output logic [31:0] rdData_q
);

    logic [31:0] mem [0:15]; // no reset: contents only matter once written

    // write port
    always_ff @(posedge clk_sys)
    begin
        if (clkEn && wrEn)
            mem[wrIdx] <= wrData;
    end

    // registered read port
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            rdData_q <= 32'h0000_0000;
        else if (clkEn && rdEn)
            rdData_q <= mem[rdIdx];
    end

endmodule : fpuac_ctx_mem

`default_nettype wire

//--- tb/fpuac_core_model.sv
// fpuac_core_model: fp register image of the core, read by index
// assumes: the block reads one register a cycle through cnt_q[3:0]
`timescale 1ns/1ps
`default_nettype none

module fpuac_core_model
(
    input wire logic [4:0] cnt_q,
    output logic [31:0] fpRegRdData
);
    // combinational answer, a distinct word per register so swapped indices show
    assign fpRegRdData = {28'hFACE5A0, cnt_q[3:0]};
endmodule : fpuac_core_model

`default_nettype wire

//--- tb/fpuac_top_chk.sv
// fpuac_top_chk: port assertions for the fpu access and context block
// assumes: bound into fpuac_top, one clock, clkEn held high
`timescale 1ns/1ps
`default_nettype none
`include "fpuac_consts.svh"

module fpuac_top_chk
    import fpuac_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic fpIssue,
    input wire logic fpExecute_q,
    input wire logic noCoprocessorFault_q,
    input wire logic stackPush_q,
    input wire logic [4:0] stackWordIdx_q,
    input wire logic entryDone_q,
    input wire logic returnDone_q,
    input wire logic restoreValid_q,
    input wire logic [3:0] restoreIdx_q,
    input wire fpuac_ctrl_t ctrl_q
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_reset_ctrl; $fell(reset) |-> ctrl_q == `FPUAC_CTRL_RESET; endproperty
    a_reset_ctrl: assert property (p_reset_ctrl) else $error("ctrl not at reset value");
    property p_exec_on; fpExecute_q |-> $past(fpIssue) && $past(ctrl_q.enable); endproperty
    a_exec_on: assert property (p_exec_on) else $error("execute while off");
    property p_fault_off; noCoprocessorFault_q |-> $past(fpIssue) && !$past(ctrl_q.enable); endproperty
    a_fault_off: assert property (p_fault_off) else $error("fault while on");
    // the last frame word and the done pulse coincide
    property p_entry_len;
        entryDone_q |-> stackPush_q && stackWordIdx_q == ((ctrl_q.stackMode == `FPUAC_STACK_FULL) ? 5'h19 : 5'h07);
    endproperty
    a_entry_len: assert property (p_entry_len) else $error("entry frame length");
    property p_none_no_fp;
        stackPush_q && stackWordIdx_q > 5'h07 |-> ctrl_q.stackMode inside {`FPUAC_STACK_FULL, `FPUAC_STACK_LAZY};
    endproperty
    a_none_no_fp: assert property (p_none_no_fp) else $error("fp words without stacking");
    property p_lazy_save;
        stackPush_q && stackWordIdx_q == 5'h19 && ctrl_q.stackMode == `FPUAC_STACK_LAZY |-> ##[1:3] fpExecute_q;
    endproperty
    a_lazy_save: assert property (p_lazy_save) else $error("lazy save not followed by execute");
    property p_restore_seq;
        restoreValid_q && restoreIdx_q != 4'hF |=> restoreValid_q && restoreIdx_q == $past(restoreIdx_q) + 4'h1;
    endproperty
    a_restore_seq: assert property (p_restore_seq) else $error("restore run broken");
    property p_return_done; restoreValid_q && restoreIdx_q == 4'hF |-> returnDone_q; endproperty
    a_return_done: assert property (p_return_done) else $error("return not done");
endmodule : fpuac_top_chk

bind fpuac_top fpuac_top_chk fpuac_top_chk_inst (.clk_sys(clk_sys), .reset(reset), .fpIssue(fpIssue),
    .fpExecute_q(fpExecute_q), .noCoprocessorFault_q(noCoprocessorFault_q), .stackPush_q(stackPush_q),
    .stackWordIdx_q(stackWordIdx_q), .entryDone_q(entryDone_q), .returnDone_q(returnDone_q),
    .restoreValid_q(restoreValid_q), .restoreIdx_q(restoreIdx_q), .ctrl_q(ctrl_q));

`default_nettype wire

//--- tb/fpuac_top_test.sv
// fpuac_top_test: self-checking bench for the fpu access and context block
// assumes: core model answers register reads, bench plays bus master and core
`timescale 1ns/1ps
`default_nettype none
`include "fpuac_consts.svh"

module fpuac_top_test
    import fpuac_pkg::*;
;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    fpuac_avs_req_t avsReq = '0;
    fpuac_avs_rsp_t avsRsp_q;
    logic fpIssue = 1'b0;
    logic excEntry = 1'b0;
    logic excReturn = 1'b0;
    logic [5:0] fpExcFlags = 6'h00;
    logic [31:0] fpRegRdData;
    logic fpExecute_q, noCoprocessorFault_q, stackPush_q, entryDone_q, returnDone_q, restoreValid_q, irq_q;
    logic [4:0] cnt_q, stackWordIdx_q, frameWords_q;
    logic [3:0] restoreIdx_q;
    logic [31:0] restoreData_q, rd;
    fpuac_ctrl_t ctrl_q;
    int failCount = 0;
    int nTests = 0;
    int pushes = 0;
    int restores = 0;
    logic [7:0] seed = 8'h53; // lfsr start
    logic [7:0] v;
    logic [1:0] m;
    logic f, ans;

    fpuac_top fpuac_top_inst (.clk_sys(clk_sys), .reset(reset), .clkEn(1'b1), .avsReq(avsReq),
        .avsRsp_q(avsRsp_q), .fpIssue(fpIssue), .excEntry(excEntry), .excReturn(excReturn),
        .fpExcFlags(fpExcFlags), .fpRegRdData(fpRegRdData), .fpExecute_q(fpExecute_q),
        .noCoprocessorFault_q(noCoprocessorFault_q), .cnt_q(cnt_q), .stackPush_q(stackPush_q),
        .stackWordIdx_q(stackWordIdx_q), .frameWords_q(frameWords_q), .entryDone_q(entryDone_q),
        .returnDone_q(returnDone_q), .restoreValid_q(restoreValid_q), .restoreIdx_q(restoreIdx_q),
        .restoreData_q(restoreData_q), .ctrl_q(ctrl_q), .irq_q(irq_q));
    fpuac_core_model fpuac_core_model_inst (.cnt_q(cnt_q), .fpRegRdData(fpRegRdData));

    // 100 mhz clock
    initial
    begin
        forever #5 clk_sys = ~clk_sys;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    // whether the fp context ends up on the stack for this mode
    function automatic logic saved(input logic [1:0] md, input logic fp);
        return md == `FPUAC_STACK_FULL || (md == `FPUAC_STACK_LAZY && fp);
    endfunction : saved

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        nTests++;
        if (got !== exp)
        begin
            failCount++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask : chk

    task automatic print_verdict;
        $display("tests %0d mismatches %0d", nTests, failCount);
        if (failCount == 0 && nTests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict

    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd, output logic [31:0] rv);
        @(posedge clk_sys);
        avsReq <= '{read: !wr, write: wr, address: adr, writedata: wd};
        do
            @(posedge clk_sys);
        while (avsRsp_q.waitrequest !== 1'b0);
        rv = avsRsp_q.readdata;
        avsReq <= '0;
    endtask : bus

    task automatic rd_chk(input logic [3:0] adr, input logic [31:0] exp, input string msg);
        bus(1'b0, adr, 32'h0, rd);
        chk(rd, exp, msg);
    endtask : rd_chk

    // core side: hold fpIssue until one answer, drop it at that edge
    task automatic issue(output logic flt);
        @(posedge clk_sys);
        fpIssue <= 1'b1;
        do
            @(posedge clk_sys);
        while (fpExecute_q !== 1'b1 && noCoprocessorFault_q !== 1'b1);
        flt = noCoprocessorFault_q;
        fpIssue <= 1'b0;
    endtask : issue

    // one-cycle entry or return pulse, then wait for its done pulse
    task automatic exc(input logic ret);
        @(posedge clk_sys);
        excEntry <= !ret;
        excReturn <= ret;
        @(posedge clk_sys);
        excEntry <= 1'b0;
        excReturn <= 1'b0;
        while ((ret ? returnDone_q : entryDone_q) !== 1'b1)
            @(posedge clk_sys);
        // one more edge so the monitor has counted the last word
        @(posedge clk_sys);
    endtask : exc

    // counts frame words and checks restored words against the core image
    always @(posedge clk_sys)
    begin
        if (stackPush_q === 1'b1)
            pushes++;
        if (restoreValid_q === 1'b1)
        begin
            restores++;
            chk(restoreData_q, {28'hFACE5A0, restoreIdx_q}, "restore data");
        end
    end

    // watchdog, far above the few hundred cycles the tests need
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        failCount++;
        print_verdict();
    end

    initial
    begin
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        rd_chk(`FPUAC_OFS_CTRL, 32'h4, "ctrl reset");
        rd_chk(4'h2, 32'h0, "unmapped read");
        // six exception flags, then a fault from the disabled unit
        for (int k = 0; k < 7; k++)
        begin
            bus(1'b1, `FPUAC_OFS_IRQ_MASK, 32'h0, rd);
            if (k < 6)
            begin
                @(posedge clk_sys);
                fpExcFlags <= 6'h01 << k;
                @(posedge clk_sys);
                fpExcFlags <= 6'h00;
            end
            else
            begin
                issue(ans);
                chk({31'h0, ans}, 32'h1, "fault when off");
            end
            rd_chk(`FPUAC_OFS_IRQ_STAT, 32'h1 << k, "sticky flag");
            chk({31'h0, irq_q}, 32'h0, "masked irq");
            bus(1'b1, `FPUAC_OFS_IRQ_MASK, 32'h1 << k, rd);
            repeat (2) @(posedge clk_sys);
            chk({31'h0, irq_q}, 32'h1, "unmasked irq");
            bus(1'b1, `FPUAC_OFS_IRQ_STAT, 32'h1 << k, rd);
            repeat (2) @(posedge clk_sys);
            chk({31'h0, irq_q}, 32'h0, "cleared irq");
        end
        // random mode bits, every rounding mode, unmapped write ignored
        for (int i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            v = {i[1:0], seed[5:3], `FPUAC_STACK_LAZY, 1'b0};
            bus(1'b1, `FPUAC_OFS_CTRL, {24'h0, v}, rd);
            bus(1'b1, 4'h2, {seed, seed, seed, seed}, rd);
            rd_chk(`FPUAC_OFS_CTRL, {24'h0, v}, "ctrl readback");
            chk({24'h0, ctrl_q}, {24'h0, v}, "mode outputs");
        end
        // none with fp use, full, lazy idle, lazy with fp use
        for (int c = 0; c < 4; c++)
        begin
            m = (c == 0) ? `FPUAC_STACK_NONE : (c == 1) ? `FPUAC_STACK_FULL : `FPUAC_STACK_LAZY;
            f = (c == 0) || (c == 3);
            bus(1'b1, `FPUAC_OFS_CTRL, {29'h0, m, 1'b1}, rd);
            pushes = 0;
            restores = 0;
            exc(1'b0);
            chk({27'h0, frameWords_q}, (m == `FPUAC_STACK_NONE) ? 32'h8 : 32'h1A, "frame size");
            chk(pushes, (m == `FPUAC_STACK_FULL) ? 32'h1A : 32'h8, "entry words");
            rd_chk(`FPUAC_OFS_STATUS, {22'h0, (m == `FPUAC_STACK_NONE) ? 5'h08 : 5'h1A, 2'h0,
                m == `FPUAC_STACK_FULL, m == `FPUAC_STACK_LAZY, 1'b1}, "status after entry");
            if (f)
            begin
                issue(ans);
                chk({31'h0, ans}, 32'h0, "execute when on");
            end
            chk(pushes, saved(m, f) ? 32'h1A : 32'h8, "words after fp use");
            exc(1'b1);
            chk(restores, saved(m, f) ? 32'h10 : 32'h0, "restored regs");
        end
        // second reset in mid-run
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        rd_chk(`FPUAC_OFS_CTRL, 32'h4, "ctrl after reset");
        print_verdict();
    end
endmodule : fpuac_top_test

`default_nettype wire
